/* File: fssc_pkg.sv */
// Constants and state types for the flash store security control block.
// Assumes an 8-bit special-function register bus and a 16-bit move-write address.
package fssc_pkg;
   localparam int          ADDR_W        = 16;
   localparam int          PAGE_LSB      = 9;
   localparam int          PAGE_W        = ADDR_W - PAGE_LSB;
   localparam logic [7:0]  PROGRAM_STORE_CONTROL_ADDR    = 8'h8f;
   localparam logic [7:0]  KEY_ADDR      = 8'hb7;
   localparam logic [7:0]  KEY_FIRST     = 8'ha5;
   localparam logic [7:0]  KEY_SECOND    = 8'hf1;
   localparam int          WE_BIT        = 0;
   localparam int          EE_BIT        = 1;
   localparam logic [7:0]  LOCK_NONE     = 8'hff;
   localparam logic [7:0]  RDATA_ZERO    = 8'h00;
   localparam logic [5:0]  UNUSED_ZERO   = 6'h00;
   localparam logic [1:0]  DBG_WRITE     = 2'h0;
   localparam logic [1:0]  DBG_PAGE_ERASE = 2'h1;
   localparam logic [1:0]  DBG_DEV_ERASE = 2'h2;

   typedef enum logic [3:0] {
      FSSC_KEY_IDLE   = 4'h1,
      FSSC_KEY_FIRST  = 4'h2,
      FSSC_KEY_OPEN   = 4'h4,
      FSSC_KEY_DEAD   = 4'h8
   } fssc_key_state_t;

   typedef struct packed {
      fssc_key_state_t state;
      logic            unlocked;
   } fssc_key_st_t;

   typedef struct packed {
      logic              we;
      logic              ee;
      logic [7:0]        lock_byte;
      logic [7:0]        lock_act;
      logic              lock_wr;
      logic              fflag;
      logic              busy;
      logic              xram_wr;
      logic              prog;
      logic              erase;
      logic              dev_erase;
      logic              dbg_taken;
      logic              fault_rst;
      logic [ADDR_W-1:0] addr;
      logic [7:0]        data;
      logic [7:0]        rdata;
   } fssc_st_t;
endpackage

/* File: fssc_key.sv */
// Unlock key sequencer for flash writes and erases.
// Assumes key writes and operation attempts arrive as one-cycle synchronous pulses.
module fssc_key (
   input  wire logic       i_clk,
   input  wire logic       i_rst_n,
   input  wire logic       i_clear,
   input  wire logic       i_key_wr,
   input  wire logic [7:0] i_key_data,
   input  wire logic       i_consume,
   output logic            o_unlocked
);
   import fssc_pkg::*;

   fssc_key_st_t s_ff;
   fssc_key_st_t nxt_s;

   always_comb begin
      nxt_s = s_ff;
      if (i_clear) begin
         nxt_s.state = FSSC_KEY_IDLE;
      end else if (i_consume) begin
         // An unkeyed attempt locks out until reset; a keyed one re-arms the lock.
         nxt_s.state = (s_ff.state == FSSC_KEY_OPEN) ? FSSC_KEY_IDLE : FSSC_KEY_DEAD;
      end else if (i_key_wr) begin
         case (s_ff.state)
            FSSC_KEY_IDLE: begin
               nxt_s.state = (i_key_data == KEY_FIRST) ? FSSC_KEY_FIRST : FSSC_KEY_DEAD;
            end
            FSSC_KEY_FIRST: begin
               nxt_s.state = (i_key_data == KEY_SECOND) ? FSSC_KEY_OPEN : FSSC_KEY_DEAD;
            end
            FSSC_KEY_OPEN: begin
               nxt_s.state = FSSC_KEY_DEAD;
            end
            default: begin
               nxt_s.state = FSSC_KEY_DEAD;
            end
         endcase
      end
      nxt_s.unlocked = (nxt_s.state == FSSC_KEY_OPEN);
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         s_ff <= '{state: FSSC_KEY_IDLE, unlocked: 1'b0};
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign o_unlocked = s_ff.unlocked;
endmodule // fssc_key

/* File: fssc_top.sv */
// Flash store security control: program-store control register, move-write
// redirection, page erase, page locking and the flash fault reset.
// Assumes all inputs are synchronous to i_clk and that the core stalls while o_cpu_stall is high.
module fssc_top #(
   parameter logic [16:0] USER_BYTES = 17'h03e00
) (
   input  wire logic                        i_clk,
   input  wire logic                        i_rst_n,
   input  wire logic                        i_dev_reset,
   input  wire logic                        i_sfr_wr,
   input  wire logic                        i_sfr_rd,
   input  wire logic [7:0]                  i_sfr_addr,
   input  wire logic [7:0]                  i_sfr_wdata,
   input  wire logic                        i_mw_valid,
   input  wire logic [fssc_pkg::ADDR_W-1:0] i_mw_addr,
   input  wire logic [7:0]                  i_mw_data,
   input  wire logic [fssc_pkg::ADDR_W-1:0] i_pc,
   input  wire logic                        i_dbg_valid,
   input  wire logic [1:0]                  i_dbg_op,
   input  wire logic [fssc_pkg::ADDR_W-1:0] i_dbg_addr,
   input  wire logic [7:0]                  i_dbg_data,
   input  wire logic                        i_flash_done,
   output logic [7:0]                       o_sfr_rdata,
   output logic                             o_xram_wr,
   output logic                             o_flash_prog,
   output logic                             o_flash_erase,
   output logic                             o_flash_dev_erase,
   output logic [fssc_pkg::ADDR_W-1:0]      o_addr,
   output logic [7:0]                       o_data,
   output logic                             o_cpu_stall,
   output logic                             o_irq_hold,
   output logic                             o_dbg_taken,
   output logic                             o_fault_reset,
   output logic                             o_flash_fault_reset_flag,
   output logic                             o_store_write_enable,
   output logic                             o_store_erase_enable
);
   import fssc_pkg::*;

   localparam logic [16:0] PAGE_BYTES = 17'h00200;
   localparam logic [ADDR_W-1:0] LOCK_ADDR  = ADDR_W'(USER_BYTES - 17'h00001);
   localparam logic [PAGE_W-1:0] LOCK_PAGE  = LOCK_ADDR[ADDR_W-1:PAGE_LSB];

   initial begin
      if ((USER_BYTES % PAGE_BYTES) != 17'h0 || USER_BYTES == 17'h0 || USER_BYTES > 17'h10000) begin
         $error("USER_BYTES must be a nonzero multiple of the page size within the address space.");
      end
   end

   fssc_st_t s_ff;
   fssc_st_t nxt_s;
   logic     key_unlocked;
   logic     key_use;
   logic     key_clear;
   logic     key_wr;
   logic     any_lock;
   logic [7:0] npages;

   assign any_lock = (s_ff.lock_act != LOCK_NONE);
   assign npages   = ~s_ff.lock_act;

   function automatic logic page_locked(input logic [ADDR_W-1:0] a);
      logic [PAGE_W-1:0] pg;
      pg = a[ADDR_W-1:PAGE_LSB];
      page_locked = ({1'b0, pg} < npages) || (any_lock && pg == LOCK_PAGE);
   endfunction

   function automatic logic reserved(input logic [ADDR_W-1:0] a);
      reserved = ({1'b0, a} >= USER_BYTES);
   endfunction

   assign key_clear = s_ff.fault_rst || i_dev_reset;
   assign key_wr    = i_sfr_wr && (i_sfr_addr == KEY_ADDR);

   always_comb begin
      logic fw_bad;
      logic dbg_bad;
      fw_bad  = 1'b0;
      dbg_bad = 1'b0;
      nxt_s   = s_ff;
      key_use = 1'b0;
      nxt_s.xram_wr   = 1'b0;
      nxt_s.prog      = 1'b0;
      nxt_s.erase     = 1'b0;
      nxt_s.dev_erase = 1'b0;
      nxt_s.dbg_taken = 1'b0;
      nxt_s.fault_rst = 1'b0;
      nxt_s.rdata     = RDATA_ZERO;
      if (key_clear) begin
         nxt_s.we       = 1'b0;
         nxt_s.ee       = 1'b0;
         nxt_s.busy     = 1'b0;
         nxt_s.lock_act = s_ff.lock_byte;
         nxt_s.fflag    = s_ff.fault_rst;
      end else begin
         if (s_ff.busy && i_flash_done) begin
            nxt_s.busy = 1'b0;
         end
         if (i_sfr_wr && i_sfr_addr == PROGRAM_STORE_CONTROL_ADDR) begin
            nxt_s.we = i_sfr_wdata[WE_BIT];
            nxt_s.ee = i_sfr_wdata[EE_BIT];
         end
         if (i_sfr_rd && i_sfr_addr == PROGRAM_STORE_CONTROL_ADDR) begin
            nxt_s.rdata = {UNUSED_ZERO, s_ff.ee, s_ff.we};
         end
         if (!s_ff.busy && i_mw_valid) begin
            nxt_s.addr = i_mw_addr;
            nxt_s.data = i_mw_data;
            if (!s_ff.we) begin
               nxt_s.xram_wr = 1'b1;
            end else begin
               key_use = 1'b1;
               fw_bad  = reserved(i_mw_addr)
                      || (s_ff.ee && i_mw_addr[ADDR_W-1:PAGE_LSB] == LOCK_PAGE)
                      || (!s_ff.ee && i_mw_addr == LOCK_ADDR && s_ff.lock_wr)
                      || (page_locked(i_mw_addr) && !page_locked(i_pc));
               if (key_unlocked && fw_bad) begin
                  nxt_s.fault_rst = 1'b1;
               end else if (key_unlocked) begin
                  nxt_s.busy  = 1'b1;
                  nxt_s.erase = s_ff.ee;
                  nxt_s.prog  = !s_ff.ee;
                  if (!s_ff.ee && i_mw_addr == LOCK_ADDR) begin
                     nxt_s.lock_byte = s_ff.lock_byte & i_mw_data;
                     nxt_s.lock_wr   = 1'b1;
                  end
               end
            end
         end else if (!s_ff.busy && i_dbg_valid) begin
            nxt_s.dbg_taken = 1'b1;
            nxt_s.addr      = i_dbg_addr;
            nxt_s.data      = i_dbg_data;
            if (i_dbg_op == DBG_DEV_ERASE) begin
               nxt_s.dev_erase = 1'b1;
               nxt_s.busy      = 1'b1;
               nxt_s.lock_byte = LOCK_NONE;
               nxt_s.lock_act  = LOCK_NONE;
               nxt_s.lock_wr   = 1'b0;
            end else begin
               dbg_bad = reserved(i_dbg_addr) || page_locked(i_dbg_addr)
                      || (i_dbg_op == DBG_WRITE && i_dbg_addr == LOCK_ADDR && s_ff.lock_wr)
                      || (i_dbg_op != DBG_WRITE && i_dbg_op != DBG_PAGE_ERASE);
               if (!dbg_bad) begin
                  nxt_s.busy  = 1'b1;
                  nxt_s.erase = (i_dbg_op == DBG_PAGE_ERASE);
                  nxt_s.prog  = (i_dbg_op == DBG_WRITE);
                  if (i_dbg_op == DBG_WRITE && i_dbg_addr == LOCK_ADDR) begin
                     nxt_s.lock_byte = s_ff.lock_byte & i_dbg_data;
                     nxt_s.lock_wr   = 1'b1;
                  end
               end
            end
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         s_ff <= '{lock_byte: LOCK_NONE, lock_act: LOCK_NONE, rdata: RDATA_ZERO, default: '0};
      end else begin
         s_ff <= nxt_s;
      end
   end

   fssc_key u_key (
      .i_clk      (i_clk),
      .i_rst_n    (i_rst_n),
      .i_clear    (key_clear),
      .i_key_wr   (key_wr),
      .i_key_data (i_sfr_wdata),
      .i_consume  (key_use),
      .o_unlocked (key_unlocked)
   );

   assign o_sfr_rdata              = s_ff.rdata;
   assign o_xram_wr                = s_ff.xram_wr;
   assign o_flash_prog             = s_ff.prog;
   assign o_flash_erase            = s_ff.erase;
   assign o_flash_dev_erase        = s_ff.dev_erase;
   assign o_addr                   = s_ff.addr;
   assign o_data                   = s_ff.data;
   assign o_cpu_stall              = s_ff.busy;
   assign o_irq_hold               = s_ff.busy;
   assign o_dbg_taken              = s_ff.dbg_taken;
   assign o_fault_reset            = s_ff.fault_rst;
   assign o_flash_fault_reset_flag = s_ff.fflag;
   assign o_store_write_enable     = s_ff.we;
   assign o_store_erase_enable     = s_ff.ee;
endmodule // fssc_top

/* File: fssc_top_chk.sv */
// Assertions on the ports of the flash store security control top.
// Assumes it is bound into fssc_top and sees only that module's ports.
module fssc_top_chk
   import fssc_pkg::*;
(
   input wire logic       i_clk,
   input wire logic       i_rst_n,
   input wire logic       i_dev_reset,
   input wire logic       i_sfr_rd,
   input wire logic       i_sfr_wr,
   input wire logic [7:0] i_sfr_addr,
   input wire logic       i_mw_valid,
   input wire logic       i_flash_done,
   input wire logic [7:0] o_sfr_rdata,
   input wire logic       o_xram_wr,
   input wire logic       o_flash_prog,
   input wire logic       o_flash_erase,
   input wire logic       o_cpu_stall,
   input wire logic       o_irq_hold,
   input wire logic       o_dbg_taken,
   input wire logic       o_fault_reset,
   input wire logic       o_flash_fault_reset_flag,
   input wire logic       o_store_write_enable,
   input wire logic       o_store_erase_enable
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   logic quiet;
   assign quiet = !i_dev_reset && !o_fault_reset && !o_cpu_stall;
   sequence s_op_start; o_flash_prog || o_flash_erase; endsequence
   sequence s_op_end; o_cpu_stall && i_flash_done; endsequence
   ctl_readback_a: assert property (i_sfr_rd && !i_sfr_wr && i_sfr_addr == PROGRAM_STORE_CONTROL_ADDR && quiet
      |=> o_sfr_rdata == {UNUSED_ZERO, o_store_erase_enable, o_store_write_enable}) else $error("bad readback");
   xram_route_a: assert property (i_mw_valid && !o_store_write_enable && quiet |=> o_xram_wr)
      else $error("move write not sent to xram");
   flash_route_a: assert property (i_mw_valid && o_store_write_enable && quiet |=> !o_xram_wr)
      else $error("move write leaked to xram");
   erase_enables_a: assert property (o_flash_erase && !o_dbg_taken
      |-> $past(o_store_erase_enable) && $past(o_store_write_enable)) else $error("erase without enables");
   prog_enables_a: assert property (o_flash_prog && !o_dbg_taken |-> !$past(o_store_erase_enable))
      else $error("write while erase enabled");
   irq_held_a: assert property (s_op_start |-> o_irq_hold && o_cpu_stall) else $error("irq not held");
   irq_release_a: assert property (s_op_end |=> !o_irq_hold) else $error("irq hold stuck");
   fault_flag_a: assert property (o_fault_reset |=> o_flash_fault_reset_flag) else $error("fault flag not set");
   dbg_no_reset_a: assert property (o_dbg_taken |-> !o_fault_reset) else $error("debug caused reset");
endmodule // fssc_top_chk

/* File: fssc_flash_model.sv */
// Flash array model: answers each operation with a done pulse.
// Assumes start pulses arrive only while the block is idle.
module fssc_flash_model (
   input  wire logic i_clk,
   input  wire logic i_rst_n,
   input  wire logic i_start,
   output logic      o_done
);
   logic [3:0] cnt_ff;
   logic       slow_ff;
   // Alternates a prompt and a slow answer.
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cnt_ff <= 4'h0;
         slow_ff <= 1'b0;
         o_done <= 1'b0;
      end else begin
         o_done <= cnt_ff == 4'h1;
         if (i_start) begin
            cnt_ff <= slow_ff ? 4'h6 : 4'h1;
            slow_ff <= !slow_ff;
         end else if (cnt_ff != 4'h0) begin
            cnt_ff <= cnt_ff - 4'h1;
         end
      end
   end
endmodule // fssc_flash_model

/* File: fssc_top_bench.sv */
// Self-checking bench for the flash store security control top.
// Assumes the flash array model answers within a few cycles.
module fssc_top_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import fssc_pkg::*;
   typedef struct packed {logic [7:0] ctl; logic key; logic [15:0] addr; logic [3:0] exp;} fssc_row_t;
   logic clk, rst_n, dev_rst, sfr_wr, sfr_rd, mw_valid, dbg_valid, done;
   logic [7:0] sfr_addr, sfr_wdata, mw_data, dbg_data, rdata, data_o;
   logic [15:0] mw_addr, pc, dbg_addr, addr_o;
   logic [1:0] dbg_op;
   logic xram, prog, erase, dev_erase, stall, hold, taken, fault, flag, we, ee;
   int n_mismatch = 0;
   int n_compared = 0;
   fssc_row_t rows [7] = '{'{8'h00, 1'b0, 16'h0100, 4'h8}, '{8'h01, 1'b1, 16'h0100, 4'h4},
      '{8'h03, 1'b1, 16'h0200, 4'h2}, '{8'h01, 1'b1, 16'h3e00, 4'h1}, '{8'h03, 1'b1, 16'h3dff, 4'h1},
      '{8'h01, 1'b0, 16'h0100, 4'h0}, '{8'h02, 1'b1, 16'h0100, 4'h8}};
   fssc_top i_dut (.i_clk(clk), .i_rst_n(rst_n), .i_dev_reset(dev_rst), .i_sfr_wr(sfr_wr), .i_sfr_rd(sfr_rd),
      .i_sfr_addr(sfr_addr), .i_sfr_wdata(sfr_wdata), .i_mw_valid(mw_valid), .i_mw_addr(mw_addr),
      .i_mw_data(mw_data), .i_pc(pc), .i_dbg_valid(dbg_valid), .i_dbg_op(dbg_op), .i_dbg_addr(dbg_addr),
      .i_dbg_data(dbg_data), .i_flash_done(done), .o_sfr_rdata(rdata), .o_xram_wr(xram), .o_flash_prog(prog),
      .o_flash_erase(erase), .o_flash_dev_erase(dev_erase), .o_addr(addr_o), .o_data(data_o), .o_cpu_stall(stall),
      .o_irq_hold(hold), .o_dbg_taken(taken), .o_fault_reset(fault), .o_flash_fault_reset_flag(flag),
      .o_store_write_enable(we), .o_store_erase_enable(ee));
   fssc_flash_model i_flash (.i_clk(clk), .i_rst_n(rst_n), .i_start(prog | erase | dev_erase), .o_done(done));
   task automatic report_and_stop;
      if (n_mismatch == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic sw(input logic [7:0] a, input logic [7:0] d);
      sfr_addr = a;
      sfr_wdata = d;
      sfr_wr = 1'b1;
      cyc(1);
      sfr_wr = 1'b0;
      cyc(1);
   endtask
   task automatic key;
      sw(KEY_ADDR, KEY_FIRST);
      sw(KEY_ADDR, KEY_SECOND);
   endtask
   // Firmware enables writes here, in the row loop, in the readback test and in the key test, with interrupts off, on the internal clock, the supply
   // monitor armed and reset causes written whole; out-of-bounds addresses are sent only on purpose.
   task automatic arm(input logic [7:0] ctl);
      sw(PROGRAM_STORE_CONTROL_ADDR, ctl);
      key();
   endtask
   task automatic dr;
      dev_rst = 1'b1;
      cyc(1);
      dev_rst = 1'b0;
      cyc(1);
   endtask
   task automatic idle;
      for (int i = 0; i < 40 && stall !== 1'b0; i++) cyc(1);
      if (stall !== 1'b0) begin
         n_mismatch++;
         report_and_stop();
      end
      cyc(1);
   endtask
   task automatic mw(input logic [15:0] a, input logic [7:0] d, input logic [3:0] exp);
      mw_addr = a;
      mw_data = d;
      mw_valid = 1'b1;
      cyc(1);
      mw_valid = 1'b0;
      chk("mw_outcome", {12'h000, xram, prog, erase, fault}, {12'h000, exp});
      chk("mw_addr", addr_o, a);
      chk("mw_data", {8'h00, data_o}, {8'h00, d});
      idle();
   endtask
   task automatic dbg(input logic [1:0] op, input logic [15:0] a, input logic [4:0] exp);
      dbg_op = op;
      dbg_addr = a;
      dbg_valid = 1'b1;
      cyc(1);
      dbg_valid = 1'b0;
      chk("dbg_outcome", {11'h000, taken, prog, erase, dev_erase, fault}, {11'h000, exp});
      chk("dbg_addr", addr_o, a);
      idle();
   endtask
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   initial begin
      {rst_n, dev_rst, sfr_wr, sfr_rd, mw_valid, dbg_valid, dbg_op} = '0;
      {sfr_addr, sfr_wdata, mw_data, dbg_data, mw_addr, dbg_addr} = '0;
      pc = 16'h0a00;
      repeat (12) @(negedge clk);
      rst_n = 1'b1;
      cyc(1);
      foreach (rows[i]) begin
         dr();
         sw(PROGRAM_STORE_CONTROL_ADDR, rows[i].ctl);
         if (rows[i].key) key();
         mw(rows[i].addr, 8'h5a, rows[i].exp);
         chk("fault_flag", {15'h0000, flag}, {15'h0000, rows[i].exp[0]});
      end
      dr();
      sw(PROGRAM_STORE_CONTROL_ADDR, 8'hff);
      sfr_addr = PROGRAM_STORE_CONTROL_ADDR;
      sfr_rd = 1'b1;
      cyc(1);
      sfr_rd = 1'b0;
      chk("ctl_read", {8'h00, rdata}, 16'h0003);
      sw(PROGRAM_STORE_CONTROL_ADDR, 8'h01);
      sw(KEY_ADDR, KEY_FIRST);
      sw(KEY_ADDR, 8'h00);
      key();
      mw(16'h0100, 8'h11, 4'h0);
      dr();
      arm(8'h01);
      mw(16'h3dff, 8'hfe, 4'h4);
      key();
      mw(16'h0000, 8'h22, 4'h4);
      mw(16'h0100, 8'h11, 4'h0);
      dr();
      arm(8'h01);
      mw(16'h0000, 8'h22, 4'h1);
      arm(8'h01);
      mw(16'h0200, 8'h33, 4'h4);
      key();
      mw(16'h3c00, 8'h44, 4'h1);
      arm(8'h01);
      pc = 16'h0000;
      mw(16'h3dff, 8'h00, 4'h1);
      pc = 16'h0a00;
      dbg(DBG_WRITE, 16'h0000, 5'h10);
      dbg(2'h3, 16'h0200, 5'h10);
      dbg(DBG_PAGE_ERASE, 16'h0200, 5'h14);
      dbg(DBG_DEV_ERASE, 16'h0000, 5'h12);
      arm(8'h01);
      mw(16'h0000, 8'h55, 4'h4);
      report_and_stop();
   end
endmodule // fssc_top_bench
bind fssc_top fssc_top_chk i_chk (.*);
